// *** verilog/atsq_sequencer.sv ***
// Trigger sequencer: terms, levels, timers, cross arming
// Notes on behaviour
// - Too-late level starts its timer on first event; trigger if second is late.
// - Entering a level starts the timers selected for that level.
// - Timer-over trigger with data else branch: trigger only if data stays absent.
// - Advance to next level once find term is seen the programmed number of times.
// - Checking level triggers if minimum timer is under or maximum over limit.
// - Duration-qualified pattern true only after staying matched longer than duration.
// - Two edge terms ANDed are true only when both occur in one sample.
// - Each edge channel matches rising, falling or either transition.
// - On trigger the outgoing arm level goes true and stays true.
// - Arm-alone mode triggers at once on the state when arm arrives.
// - Both analyzers as timing is refused; state plus timing or two state allowed.
// - Incoming arm level is ANDed with the current level's term.
module atsq_sequencer
  import atsq_pkg::*;
(
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst,
  // Target probes and arm from the other instrument (asynchronous)
  input  wire logic [DATA_W-1:0]       probe,
  input  wire logic                    armIn,
  // Run control
  input  wire logic                    runStart,
  // Programming
  input  wire atsq_pkg::atsq_lvl_t [NLVL-1:0] lvlCfg,
  input  wire atsq_pkg::atsq_pat_t      patCfg,
  input  wire atsq_pkg::atsq_edge_t     edgeTermFirst,
  input  wire atsq_pkg::atsq_edge_t     edgeTermSecond,
  input  wire logic [1:0][TMR_W-1:0]   tmrLimit,
  input  wire atsq_pkg::atsq_arm_t      armMode,
  input  wire atsq_pkg::atsq_ana_t      anaFirst,
  input  wire atsq_pkg::atsq_ana_t      anaSecond,
  // Status
  output logic                         running,
  output logic                         triggered,
  output logic                         trigPulse,
  output logic                         armOut,
  output logic                         cfgRefused,
  output logic [LVL_W-1:0]             curLevel
);

  atsq_state_t st;
  atsq_state_t next_st;
  logic        patMatch;
  logic        patHit;
  logic        e1Hit;
  logic        e2Hit;
  logic        widthBad;
  logic [1:0]  tmrOver;
  logic        findHit;
  logic        elseHit;
  logic        armRise;
  atsq_lvl_t   cur;

  // ************************************************************
  // Term decode, shared by the find and else branches
  // ************************************************************
  function automatic logic termEval(input atsq_term_t sel, input logic pat,
                                    input logic e1, input logic e2,
                                    input logic [1:0] over, input logic wbad);
    logic r;
    r = 1'b0;
    case (sel)
      TERM_NONE:     r = 1'b0;
      TERM_ANY:      r = 1'b1;
      TERM_PAT:      r = pat;
      TERM_NOT_PAT:  r = ~pat;
      TERM_EDGE_TERM_FIRST:    r = e1;
      TERM_EDGE_TERM_SECOND:    r = e2;
      TERM_EDGE_AND: r = e1 & e2;
      TERM_TMR1_GT:  r = over[0];
      TERM_TMR2_GT:  r = over[1];
      TERM_WIDTH:    r = wbad;
      default:       r = 1'b0;
    endcase
    return r;
  endfunction : termEval

  // ************************************************************
  // Edge terms, both fed by the accepted sample and its predecessor
  // ************************************************************
  atsq_edge_match u_edge_first (
    .prevData (st.dataPrev),
    .curData  (st.dataAcc),
    .edgeCfg  (edgeTermFirst),
    .hit      (e1Hit)
  );

  atsq_edge_match u_edge_second (
    .prevData (st.dataPrev),
    .curData  (st.dataAcc),
    .edgeCfg  (edgeTermSecond),
    .hit      (e2Hit)
  );

  // ************************************************************
  // Term evaluation on the current state
  // ************************************************************
  always_comb
  begin
    logic [DUR_W-1:0] runNow;
    runNow   = '0;
    cur      = lvlCfg[st.level];
    patMatch = ((st.dataAcc ^ patCfg.value) & patCfg.mask) == '0;
    // Counting the current sample too keeps "longer than" strict
    if (patMatch)
    begin
      runNow = (st.patRun == '1) ? st.patRun : st.patRun + DUR_ONE;
    end
    patHit   = patMatch & (~patCfg.durEn | (runNow > patCfg.dur));
    tmrOver[0] = st.tmrCnt[0] > tmrLimit[0];
    tmrOver[1] = st.tmrCnt[1] > tmrLimit[1];
    widthBad = (st.tmrCnt[0] < tmrLimit[0]) | tmrOver[1];
    // Arm level gates whatever term the level already uses
    findHit  = termEval(cur.findTerm, patHit, e1Hit, e2Hit, tmrOver, widthBad) &
               ((armMode != ARM_AND) | st.armAcc);
    elseHit  = termEval(cur.elseTerm, patHit, e1Hit, e2Hit, tmrOver, widthBad);
    armRise  = st.armAcc & ~st.armPrev;
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    logic             doTrig;
    logic             doGo;
    logic [LVL_W-1:0] goTo;
    logic [CNT_W-1:0] occNext;
    logic [DUR_W-1:0] runNow;
    doTrig  = 1'b0;
    doGo    = 1'b0;
    goTo    = LVL_FIRST;
    occNext = st.occCnt + OCC_ONE;
    runNow  = '0;
    next_st = st;
    next_st.trigPulse = 1'b0;

    // Three-stage synchronisers; a bit moves once stages two and three agree
    next_st.sync1    = probe;
    next_st.sync2    = st.sync1;
    next_st.sync3    = st.sync2;
    next_st.dataAcc  = (~(st.sync2 ^ st.sync3) & st.sync2) |
                       ((st.sync2 ^ st.sync3) & st.dataAcc);
    next_st.dataPrev = st.dataAcc;
    next_st.armSync  = {st.armSync[1:0], armIn};
    if (st.armSync[1] == st.armSync[2])
    begin
      next_st.armAcc = st.armSync[1];
    end
    next_st.armPrev = st.armAcc;

    // Pattern stability counter
    if (patMatch)
    begin
      runNow = (st.patRun == '1) ? st.patRun : st.patRun + DUR_ONE;
    end
    next_st.patRun = runNow;

    // Free-running timers saturate rather than wrap
    for (int i = 0; i < 2; i++)
    begin
      if (st.tmrRun[i] && st.tmrCnt[i] != '1)
      begin
        next_st.tmrCnt[i] = st.tmrCnt[i] + TMR_ONE;
      end
    end

    // Two timing analyzers cannot coexist
    next_st.refused = (anaFirst == ANA_TIMING) && (anaSecond == ANA_TIMING);

    case (st.seq)
      SEQ_IDLE, SEQ_TRIG:
      begin
        // Waiting for a run; a triggered sequencer holds its result
      end
      SEQ_RUN:
      begin
        if (armMode == ARM_ALONE)
        begin
          doTrig = armRise;
        end
        else if (cur.tooLate)
        begin
          if (!st.tlArmed)
          begin
            if (findHit)
            begin
              // First event starts the selected timer by itself
              next_st.tlArmed           = 1'b1;
              next_st.tmrCnt[cur.tlTimer] = '0;
              next_st.tmrRun[cur.tlTimer] = 1'b1;
            end
          end
          else if (elseHit)
          begin
            // Second event in time: wait for the next first event
            next_st.tlArmed             = 1'b0;
            next_st.tmrRun[cur.tlTimer] = 1'b0;
          end
          else if (tmrOver[cur.tlTimer])
          begin
            doTrig = cur.trigLvl;
            doGo   = ~cur.trigLvl;
            goTo   = (st.level == LVL_LAST) ? st.level : st.level + 2'h1;
          end
        end
        else if (findHit)
        begin
          next_st.occCnt = occNext;
          if (occNext >= cur.occurs)
          begin
            doTrig = cur.trigLvl;
            doGo   = ~cur.trigLvl;
            goTo   = (st.level == LVL_LAST) ? st.level : st.level + 2'h1;
          end
        end
        else if (elseHit)
        begin
          // Expected data seen before the limit: back to the goto level
          doGo = 1'b1;
          goTo = cur.elseGoto;
        end
      end
      default:
      begin
        next_st.seq = SEQ_IDLE;
      end
    endcase

    // Level entry clears occurrences and starts the chosen timers
    if (doGo)
    begin
      next_st.level   = goTo;
      next_st.occCnt  = '0;
      next_st.tlArmed = 1'b0;
      for (int i = 0; i < 2; i++)
      begin
        if (lvlCfg[goTo].tmrStart[i])
        begin
          next_st.tmrCnt[i] = '0;
          next_st.tmrRun[i] = 1'b1;
        end
      end
    end

    if (doTrig)
    begin
      next_st.seq       = SEQ_TRIG;
      next_st.trigPulse = 1'b1;
      next_st.armOut    = 1'b1;
      next_st.tmrRun    = '0;
    end

    // Run start wins over everything unless the set-up is refused, and restarts at level one
    if (runStart && !st.refused)
    begin
      next_st.seq     = SEQ_RUN;
      next_st.level   = LVL_FIRST;
      next_st.occCnt  = '0;
      next_st.tlArmed = 1'b0;
      next_st.armOut  = 1'b0;
      next_st.trigPulse = 1'b0;
      for (int i = 0; i < 2; i++)
      begin
        next_st.tmrCnt[i] = '0;
        next_st.tmrRun[i] = lvlCfg[LVL_FIRST].tmrStart[i];
      end
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st <= ST_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops; run and trigger codes each own one bit
  assign running    = st.seq[0];
  assign triggered  = st.seq[1];
  assign trigPulse  = st.trigPulse;
  assign armOut     = st.armOut;
  assign cfgRefused = st.refused;
  assign curLevel   = st.level;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_run_level;
    st.seq == SEQ_RUN && armMode == ARM_NONE && st.occCnt == '0 && cur.occurs <= OCC_ONE;
  endsequence

  sequence s_tl_first;
    st.seq == SEQ_RUN && armMode != ARM_ALONE && cur.tooLate && !st.tlArmed && findHit &&
    !runStart;
  endsequence

  sequence s_tl_started(logic sel);
    st.tlArmed && st.tmrRun[sel] && st.tmrCnt[sel] == '0;
  endsequence

  a_run_clears: assert property (
    runStart && !st.refused |=> st.level == LVL_FIRST && st.occCnt == '0 && !armOut && running)
    else $error("run start did not restart the sequence");

  a_arm_holds: assert property (
    trigPulse && !runStart |=> armOut && triggered)
    else $error("arm level not held after trigger");

  a_trig_arm: assert property (
    $rose(triggered) |-> armOut && trigPulse)
    else $error("trigger without arm level");

  a_both_timing: assert property (
    anaFirst == ANA_TIMING && anaSecond == ANA_TIMING |=> cfgRefused)
    else $error("dual timing configuration accepted");

  // A refused set-up must never let a run begin
  a_refused_idle: assert property (
    cfgRefused && !running |=> !running)
    else $error("run started on a refused configuration");

  a_arm_alone: assert property (
    st.seq == SEQ_RUN && armMode == ARM_ALONE && armRise && !runStart |=> trigPulse)
    else $error("arm-alone did not trigger at once");

  a_tl_start: assert property (
    s_tl_first |=> s_tl_started($past(cur.tlTimer)))
    else $error("too-late timer not started on first event");

  a_entry_timer: assert property (
    running && $changed(st.level) && lvlCfg[st.level].tmrStart[0] |->
    st.tmrCnt[0] == '0 && st.tmrRun[0])
    else $error("entry did not start the first timer");

  a_width_check: assert property (
    s_run_level and (!cur.tooLate && cur.trigLvl && cur.findTerm == TERM_WIDTH && widthBad &&
    !runStart) |=> trigPulse)
    else $error("pulse width violation missed");

  a_edge_and: assert property (
    s_run_level and (!cur.tooLate && cur.trigLvl && cur.findTerm == TERM_EDGE_AND &&
    e1Hit && e2Hit && !runStart) |=> trigPulse)
    else $error("coincident edges did not trigger");

  a_advance: assert property (
    s_run_level and (!cur.tooLate && !cur.trigLvl && findHit && st.level != LVL_LAST &&
    !runStart) |=> st.level == $past(st.level) + 2'h1 && st.occCnt == '0)
    else $error("level did not advance on find count");

  a_dur_stable: assert property (
    patCfg.durEn && patCfg.dur != '0 && patHit |-> $past(patMatch))
    else $error("duration term true before pattern stable");

endmodule : atsq_sequencer

// *** common/atsq_pkg.sv ***
// Shared types and constants of the analyzer trigger sequencer
package atsq_pkg;

  // ************************************************************
  // Sizes and reset values
  // ************************************************************
  localparam int DATA_W = 16;          // Probed channels
  localparam int NLVL   = 4;           // Sequence levels
  localparam int LVL_W  = 2;
  localparam int TMR_W  = 24;          // Timer width, 25 ns per count
  localparam int CNT_W  = 8;           // Occurrence counter width
  localparam int DUR_W  = 8;           // Duration qualifier width, cycles
  localparam logic [LVL_W-1:0] LVL_FIRST = 2'h0;
  localparam logic [LVL_W-1:0] LVL_LAST  = 2'h3;
  localparam logic [CNT_W-1:0] OCC_ONE   = 8'h01;
  localparam logic [TMR_W-1:0] TMR_ONE   = 24'h000001;
  localparam logic [DUR_W-1:0] DUR_ONE   = 8'h01;

  // ************************************************************
  // Enumerations
  // ************************************************************
  typedef enum logic [1:0] {
    EDGE_OFF    = 2'b00,
    EDGE_RISE   = 2'b01,
    EDGE_FALL   = 2'b10,
    EDGE_EITHER = 2'b11
  } atsq_edge_mode_t;

  typedef enum logic [3:0] {
    TERM_NONE     = 4'h0,
    TERM_ANY      = 4'h1,
    TERM_PAT      = 4'h2,
    TERM_NOT_PAT  = 4'h3,
    TERM_EDGE_TERM_FIRST    = 4'h4,
    TERM_EDGE_TERM_SECOND    = 4'h5,
    TERM_EDGE_AND = 4'h6,
    TERM_TMR1_GT  = 4'h7,
    TERM_TMR2_GT  = 4'h8,
    TERM_WIDTH    = 4'h9
  } atsq_term_t;

  typedef enum logic [1:0] {
    ARM_NONE  = 2'b00,
    ARM_AND   = 2'b01,
    ARM_ALONE = 2'b10
  } atsq_arm_t;

  typedef enum logic {
    ANA_STATE  = 1'b0,
    ANA_TIMING = 1'b1
  } atsq_ana_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_RUN  = 2'b01,
    SEQ_TRIG = 2'b10
  } atsq_seq_t;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    atsq_term_t        findTerm;   // Advance or trigger term
    atsq_term_t        elseTerm;   // Else branch term
    logic [CNT_W-1:0]  occurs;     // Required occurrences, 0 acts as 1
    logic              trigLvl;    // Level triggers instead of advancing
    logic              tooLate;    // Find-too-late macro level
    logic              tlTimer;    // Timer used by the macro
    logic [1:0]        tmrStart;   // Timers started on entry
    logic [LVL_W-1:0]  elseGoto;
  } atsq_lvl_t;

  typedef struct packed {
    logic [DATA_W-1:0] value;
    logic [DATA_W-1:0] mask;       // 1 = channel compared
    logic              durEn;
    logic [DUR_W-1:0]  dur;        // Must stay matched longer than this
  } atsq_pat_t;

  typedef struct packed {
    logic [DATA_W-1:0][1:0] mode;  // atsq_edge_mode_t per channel
  } atsq_edge_t;

  typedef struct packed {
    atsq_seq_t              seq;
    logic [LVL_W-1:0]       level;
    logic [CNT_W-1:0]       occCnt;
    logic [1:0][TMR_W-1:0]  tmrCnt;
    logic [1:0]             tmrRun;
    logic                   tlArmed;
    logic [DUR_W-1:0]       patRun;
    logic [DATA_W-1:0]      sync1;
    logic [DATA_W-1:0]      sync2;
    logic [DATA_W-1:0]      sync3;
    logic [DATA_W-1:0]      dataAcc;
    logic [DATA_W-1:0]      dataPrev;
    logic [2:0]             armSync;
    logic                   armAcc;
    logic                   armPrev;
    logic                   trigPulse;
    logic                   armOut;
    logic                   refused;
  } atsq_state_t;

  localparam atsq_state_t ST_RST = '0;

endpackage : atsq_pkg

// *** verilog/atsq_edge_match.sv ***
// Per-channel transition matcher for one edge term
module atsq_edge_match
  import atsq_pkg::*;
(
  // Samples
  input  wire logic [DATA_W-1:0] prevData,
  input  wire logic [DATA_W-1:0] curData,
  // Programming
  input  wire atsq_pkg::atsq_edge_t edgeCfg,
  // Result
  output logic                   hit
);

  logic [DATA_W-1:0] chHit;

  // ************************************************************
  // One matcher per channel; a disabled channel never matches
  // ************************************************************
  genvar ch;
  generate
    for (ch = 0; ch < DATA_W; ch++)
    begin : g_ch
      logic rise;
      logic fall;
      assign rise = ~prevData[ch] & curData[ch];
      assign fall = prevData[ch] & ~curData[ch];
      assign chHit[ch] = (edgeCfg.mode[ch][0] & rise) |
                         (edgeCfg.mode[ch][1] & fall);
    end
  endgenerate

  // Any selected transition makes the term true in this sample
  assign hit = |chHit;

endmodule : atsq_edge_match

// *** tb/atsq_target_model.sv ***
// Target system and second instrument model feeding probes and arm
module atsq_target_model
  import atsq_pkg::*;
(
  // Clock
  input  wire logic              mclk,
  // Requests from the bench
  input  wire logic [3:0]        lowReq,
  input  wire logic              armReq,
  // Toward the sequencer
  output logic [DATA_W-1:0]      probe,
  output logic                   armIn
);
  timeunit 1ns;
  timeprecision 1ps;

  // ******************************
  // Probe and arm lines
  // ******************************
  localparam bit COUNT_TIME = 1'b1;  // Time counting on when correlating
  localparam bit SCOPE_IMM  = 1'b1;  // Scope side fires at once when armed
  logic [DATA_W-5:0] noise = '0;

  // Unused lines change every cycle so a leaking mask shows up
  always @(posedge mclk)
    noise <= (DATA_W-4)'($urandom);

  // Low lines follow the bench, arm level held by the other side
  assign probe = {noise, lowReq};
  assign armIn = armReq;
endmodule : atsq_target_model

// *** tb/analyzer_trigger_sequencer_tb.sv ***
// Self-checking bench for the analyzer trigger sequencer
module analyzer_trigger_sequencer_tb
  import atsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ******************************
  // Signals
  // ******************************
  logic                  mclk = 1'b0;
  logic                  rst = 1'b1;
  logic                  runStart = 1'b0;
  logic [3:0]            lowReq = 4'h0;
  logic                  armReq = 1'b0;
  logic [DATA_W-1:0]     probe;
  logic                  armIn;
  atsq_lvl_t [NLVL-1:0]  lvlCfg = '0;
  atsq_pat_t             patCfg = '0;
  atsq_edge_t            edgeTermFirst = '0;
  atsq_edge_t            edgeTermSecond = '0;
  logic [1:0][TMR_W-1:0] tmrLimit = '0;
  atsq_arm_t             armMode = ARM_NONE;
  atsq_ana_t             anaFirst = ANA_STATE;
  atsq_ana_t             anaSecond = ANA_STATE;
  logic                  running, triggered, trigPulse, armOut, cfgRefused;
  logic [LVL_W-1:0]      curLevel;
  int                    failures = 0;
  int                    checks_done = 0;
  int                    c, n, d;
  int                    w[3] = '{4, 20, 45};
  int                    g[2] = '{5, 60};

  // Free-running sample clock
  initial
  begin
    forever #12.5 mclk = ~mclk;
  end

  atsq_target_model tgt (.mclk(mclk), .lowReq(lowReq), .armReq(armReq),
                         .probe(probe), .armIn(armIn));

  atsq_sequencer dut (.mclk(mclk), .rst(rst), .probe(probe), .armIn(armIn),
    .runStart(runStart), .lvlCfg(lvlCfg), .patCfg(patCfg),
    .edgeTermFirst(edgeTermFirst), .edgeTermSecond(edgeTermSecond),
    .tmrLimit(tmrLimit), .armMode(armMode), .anaFirst(anaFirst),
    .anaSecond(anaSecond), .running(running), .triggered(triggered),
    .trigPulse(trigPulse), .armOut(armOut), .cfgRefused(cfgRefused),
    .curLevel(curLevel));

  // ******************************
  // Shared tasks
  // ******************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    checks_done++;
    if (v !== e)
    begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, v);
    end
  endtask : chk

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // Back to a blank set-up; long enough for the probe syncs to settle
  task automatic clr;
    @(posedge mclk);
    lvlCfg <= '0;
    patCfg <= '0;
    edgeTermFirst <= '0;
    edgeTermSecond <= '0;
    tmrLimit <= '0;
    armMode <= ARM_NONE;
    anaFirst <= ANA_STATE;
    anaSecond <= ANA_STATE;
    lowReq <= 4'h0;
    armReq <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask : clr

  task automatic put(input logic [3:0] v);
    @(posedge mclk) lowReq <= v;
  endtask : put

  // Count trigger pulses over k settled cycles
  task automatic watch(input int k);
    c = 0;
    repeat (k)
    begin
      @(posedge mclk);
      #1;
      if (trigPulse === 1'b1)
        c++;
    end
  endtask : watch

  task automatic run(input bit e);
    @(posedge mclk) runStart <= 1'b1;
    @(posedge mclk) runStart <= 1'b0;
    #1 chk("running", e, running);
    if (e)
    begin
      chk("start level", 0, curLevel);
      chk("start arm", 0, armOut);
      chk("start trig", 0, triggered);
    end
  endtask : run

  // Judge one case; a trigger must hold its arm level afterwards
  task automatic tc(input string nm, input bit e);
    chk(nm, e, c != 0);
    if (e)
    begin
      chk("pulse count", 1, c);
      repeat (3) @(posedge mclk);
      #1 chk("arm held", 1, armOut);
      chk("trig held", 1, triggered);
      chk("run stopped", 0, running);
    end
    else
      chk("level back", 0, curLevel);
  endtask : tc

  // First event, then the second after gap cycles unless past the limit
  task automatic gapCase(input int gap, input int lim);
    put(4'h1);
    watch(gap);
    n = c;
    if (gap < lim)
      put(4'h3);
    watch(30);
    c = c + n;
    tc("late event", gap > lim);
  endtask : gapCase

  // ******************************
  // Main sequence
  // ******************************
  initial
  begin
    void'($urandom(32'h79771AE5));
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    // Analyzer mixes: only both timing is refused; tried first, while still idle,
    // since a refused start leaves an earlier run going
    for (int i = 3; i >= 0; i--)
    begin
      @(posedge mclk);
      anaFirst <= atsq_ana_t'(i[1]);
      anaSecond <= atsq_ana_t'(i[0]);
      repeat (2) @(posedge mclk);
      #1 chk("refused", i == 3, cfgRefused);
      run(i != 3);
    end
    // Edge modes against a rise then a fall
    for (int m = 1; m < 4; m++)
    begin
      clr();
      edgeTermFirst.mode[0] <= 2'(m);
      lvlCfg[0].findTerm <= TERM_EDGE_TERM_FIRST;
      lvlCfg[0].trigLvl <= 1'b1;
      run(1'b1);
      put(4'h1);
      watch(8);
      n = c;
      put(4'h0);
      watch(8);
      chk("rise hit", m & 1, n);
      chk("fall hit", m == 2, c);
    end
    // Random occurrence count, trigger only on the last one
    clr();
    n = 2 + $urandom % 5;
    d = n;
    edgeTermFirst.mode[0] <= EDGE_RISE;
    lvlCfg[0].findTerm <= TERM_EDGE_TERM_FIRST;
    lvlCfg[0].trigLvl <= 1'b1;
    lvlCfg[0].occurs <= CNT_W'(n);
    run(1'b1);
    for (int i = 1; i <= d; i++)
    begin
      put(4'h1);
      watch(8);
      tc("occurrence", i == d);
      put(4'h0);
      repeat (4) @(posedge mclk);
    end
    // Joint edges: each alone is not enough
    clr();
    edgeTermFirst.mode[0] <= EDGE_RISE;
    edgeTermSecond.mode[1] <= EDGE_RISE;
    lvlCfg[0].findTerm <= TERM_EDGE_AND;
    lvlCfg[0].trigLvl <= 1'b1;
    run(1'b1);
    foreach (g[i])
      n = i;
    for (int i = 0; i < 4; i++)
    begin
      put(i == 1 ? 4'h3 : (i == 2 ? 4'h0 : (i == 0 ? 4'h1 : 4'h3)));
      watch(8);
      tc("edge pair", i == 3);
    end
    // Pattern held for exactly a random duration, then past it
    for (int k = 0; k < 2; k++)
    begin
      clr();
      d = 2 + $urandom % 5;
      patCfg <= '{16'h0005, 16'h000F, 1'b1, DUR_W'(d)};
      lvlCfg[0].findTerm <= TERM_PAT;
      lvlCfg[0].trigLvl <= 1'b1;
      run(1'b1);
      put(4'h5);
      watch(k ? d + 3 : d - 1);
      n = c;
      put(4'h0);
      watch(8);
      c = c + n;
      tc("stable pattern", k == 1);
    end
    // Arm alone, then arm gating the find term
    for (int j = 0; j < 2; j++)
    begin
      clr();
      armMode <= j ? ARM_AND : ARM_ALONE;
      lvlCfg[0].findTerm <= j ? TERM_ANY : TERM_NONE;
      lvlCfg[0].trigLvl <= 1'b1;
      run(1'b1);
      watch(8);
      chk("unarmed", 0, c);
      @(posedge mclk) armReq <= 1'b1;
      watch(8);
      tc("armed", 1'b1);
    end
    // Pulse width check level, both timers started on entry to the level before it
    foreach (w[i])
    begin
      clr();
      edgeTermFirst.mode[0] <= EDGE_RISE;
      edgeTermSecond.mode[0] <= EDGE_FALL;
      lvlCfg[0].findTerm <= TERM_EDGE_TERM_FIRST;
      lvlCfg[1].findTerm <= TERM_EDGE_TERM_SECOND;
      lvlCfg[1].tmrStart <= 2'b11;
      lvlCfg[2].findTerm <= TERM_WIDTH;
      lvlCfg[2].elseTerm <= TERM_ANY;
      lvlCfg[2].trigLvl <= 1'b1;
      tmrLimit <= {24'h00001E, 24'h00000A};
      run(1'b1);
      put(4'h1);
      repeat (w[i]) @(posedge mclk);
      put(4'h0);
      watch(10);
      tc("pulse width", w[i] < 10 || w[i] > 30);
    end
    // Too-late macro level, then timer level with data else branch
    for (int j = 0; j < 4; j++)
    begin
      clr();
      edgeTermFirst.mode[0] <= EDGE_RISE;
      edgeTermSecond.mode[1] <= EDGE_RISE;
      patCfg <= '{16'h0003, 16'h000F, 1'b0, 8'h00};
      tmrLimit[0] <= 24'h000014;
      if (j < 2)
        lvlCfg[0] <= '{TERM_EDGE_TERM_FIRST, TERM_EDGE_TERM_SECOND, 8'h01, 1'b1, 1'b1, 1'b0, 2'b00, 2'h0};
      else
      begin
        lvlCfg[0].findTerm <= TERM_EDGE_TERM_FIRST;
        lvlCfg[1] <= '{TERM_TMR1_GT, TERM_PAT, 8'h01, 1'b1, 1'b0, 1'b0, 2'b01, 2'h0};
      end
      run(1'b1);
      gapCase(g[j % 2], 20);
    end
    print_verdict();
  end

  // Watchdog well past the expected run length
  initial
  begin
    #(25 * 20000);
    failures++;
    print_verdict();
  end
endmodule : analyzer_trigger_sequencer_tb
